// ==== tb_top.sv ====
/* Self-checking bench for usp_power_ctrl.
 Assumes a 200 MHz clock and the core model. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, susp = 0, ce = 1, e;
  logic [3:0] adr = 4'h0, sel = 4'h1;
  logic [31:0] wd = 32'h0, rd, rdat;
  logic ack, err, sn, rwk, wkn, xrst, xsn, blk;
  int fail_count = 0, comparisons = 0, cycles = 0;
  always #2.5 clk_i = ~clk_i;
  usp_core_model core (.clk_i(clk_i), .susp_i(susp), .suspend_n_o(sn));
  usp_power_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .core_suspend_n_i(sn),
    .core_remote_wake_o(rwk), .wake_interrupt_n_o(wkn), .transceiver_reset_output_o(xrst),
    .transceiver_suspend_output_n_o(xsn), .core_access_block_o(blk));
  task automatic report_and_stop;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Holds the request until ack or err is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat;
    e = err;
    cyc <= 1'b0;
  endtask : bus
  task automatic t_regs;
    bus(0, 4'h0, 0);
    chk(rd, 32'h30);
    bus(1, 4'h0, 32'hff);
    bus(0, 4'h0, 0);
    chk(rd, 32'hb8);
    chk({rwk, xsn, blk}, 3'b001);
    bus(1, 4'h0, 32'h00);
    chk(xrst, 1);
    bus(1, 4'h0, 32'h20);
    chk(xrst, 0);
    bus(1, 4'h4, 32'h00);
    chk({e, xrst}, 2'b10);
  endtask : t_regs
  task automatic t_quiet;
    susp <= 1'b1;
    repeat (4) @(posedge clk_i);
    susp <= 1'b0;
    @(posedge clk_i);
    #1 chk(wkn, 1);
  endtask : t_quiet
  task automatic t_wake;
    @(posedge clk_i);
    susp <= 1'b1;
    repeat (4) @(posedge clk_i);
    bus(0, 4'h0, 0);
    chk(rd, 32'h20);
    bus(1, 4'h0, 32'he8);
    bus(0, 4'h0, 0);
    chk(rd, 32'he8);
    chk({rwk, xsn, blk, wkn}, 4'b1011);
    @(posedge clk_i);
    susp <= 1'b0;
    @(posedge clk_i);
    #1 chk(wkn, 0);
    repeat (4) @(posedge clk_i);
    bus(0, 4'h0, 0);
    chk(rd, 32'hb0);
    chk({rwk, xsn, blk}, 3'b010);
  endtask : t_wake
  // Clock enable low holds the request unanswered and the bits unchanged
  task automatic t_freeze;
    @(posedge clk_i);
    ce <= 1'b0;
    cyc <= 1'b1;
    we <= 1'b1;
    adr <= 4'h0;
    wd <= 32'h28;
    repeat (4) @(posedge clk_i);
    chk({ack, err, blk, xsn}, 4'b0001);
    ce <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    cyc <= 1'b0;
    chk({blk, xsn}, 2'b10);
    bus(1, 4'h0, 32'h20);
    chk({blk, xsn}, 2'b01);
    sel <= 4'h0;
    bus(1, 4'h0, 32'h08);
    sel <= 4'h1;
    chk(blk, 0);
  endtask : t_freeze
  // Hang guard, far above the few dozen cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_quiet;
    t_wake;
    t_freeze;
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire

// ==== usp_core_model.sv ====
/* Core suspend level model.
 Assumes the bench sets the wanted state. */
`timescale 1ns/10ps
`default_nettype none
module usp_core_model (
  input wire logic clk_i,
  input wire logic susp_i,
  output logic suspend_n_o
);
  // Moves only after an edge, like the core flop
  always_ff @(posedge clk_i) begin
    suspend_n_o <= !susp_i;
  end
endmodule : usp_core_model
`default_nettype wire

// ==== usp_pkg.sv ====
/*
 Package for the USB suspend and transceiver power control block.
 Assumes a 32-bit classic Wishbone register bus, byte addressing.
*/
package usp_pkg;
  localparam int unsigned USP_AW = 4;
  localparam logic [3:0] USP_PWCTL_OFF = 4'h0;
  localparam int unsigned USP_WAKE_EN_BIT = 7;
  localparam int unsigned USP_RWAKE_BIT = 6;
  localparam int unsigned USP_XRST_BIT = 5;
  localparam int unsigned USP_SUSPX_BIT = 4;
  localparam int unsigned USP_XSUSP_BIT = 3;
  localparam logic USP_WAKE_EN_RST = 1'b0;
  localparam logic USP_RWAKE_RST = 1'b0;
  localparam logic USP_XRST_RST = 1'b1;
  localparam logic USP_XSUSP_RST = 1'b0;
  localparam logic USP_SUSPX_RST = 1'b1;
  localparam int unsigned USP_SYNC_STAGES = 2;
endpackage : usp_pkg

// ==== usp_power_ctrl.sv ====
/*
 Suspend, wakeup and transceiver power control with one Wishbone register.
 Assumes a classic Wishbone master, a USB core giving an active-low
 suspend level, and a transceiver with active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module usp_power_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [usp_pkg::USP_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic core_suspend_n_i,
  output logic core_remote_wake_o,
  output logic wake_interrupt_n_o,
  output logic transceiver_reset_output_o,
  output logic transceiver_suspend_output_n_o,
  output logic core_access_block_o
);
  import usp_pkg::*;

  logic wake_en_q;
  logic rwake_q;
  logic xrst_q;
  logic xsusp_q;
  logic xsusp_pin_n_q;
  logic suspx_s;
  logic suspx_prev_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdat_q;

  // Register and auto-clears see only the synchronised copy
  usp_sync #(.RST_VAL(USP_SUSPX_RST)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(core_suspend_n_i),
    .q_o(suspx_s)
  );

  wire req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  wire hit = (wb_adr_i == USP_PWCTL_OFF);
  wire wr_lo = req && hit && wb_we_i && wb_sel_i[0];
  wire rd_ok = req && hit && !wb_we_i;
  // Resume is the rising edge of the synchronised status
  wire resume = suspx_s && !suspx_prev_q;

  // Write data fields; only byte lane 0 holds live bits
  wire wd_wake_en = wb_dat_i[USP_WAKE_EN_BIT];
  wire wd_rwake = wb_dat_i[USP_RWAKE_BIT];
  wire wd_xrst = wb_dat_i[USP_XRST_BIT];
  wire wd_xsusp = wb_dat_i[USP_XSUSP_BIT];

  // A remote wake makes sense only while the core is suspended
  wire rwake_set_ok = wr_lo && wd_rwake && !suspx_s;

  // Resume clears win over writes in the same cycle
  wire rwake_d = resume ? 1'b0 :
    rwake_set_ok ? 1'b1 : rwake_q;
  wire xsusp_d = resume ? 1'b0 :
    wr_lo ? wd_xsusp : xsusp_q;
  // No hardware path releases the transceiver reset bit
  wire xrst_d = wr_lo ? wd_xrst : xrst_q;
  wire wake_en_d = wr_lo ? wd_wake_en : wake_en_q;
  // Pin flop loads with the bit, so pin and bit never disagree
  wire xsusp_pin_n_d = !xsusp_d;

  // Unused positions read back as zero; bit 4 reads the synchronised status
  wire [31:0] rd_word = {24'h000000, wake_en_q, rwake_q, xrst_q,
    suspx_s, xsusp_q, 3'h0};

  // Bus answer next values
  wire ack_d = req && hit;
  wire err_d = req && !hit;
  wire [31:0] rdat_d = rd_ok ? rd_word : 32'h00000000;

  // One short process per bit keeps each hold path plain to see
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_en_q <= USP_WAKE_EN_RST;
    end else if (ce_i) begin
      wake_en_q <= wake_en_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rwake_q <= USP_RWAKE_RST;
    end else if (ce_i) begin
      rwake_q <= rwake_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xrst_q <= USP_XRST_RST;
    end else if (ce_i) begin
      xrst_q <= xrst_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xsusp_q <= USP_XSUSP_RST;
    end else if (ce_i) begin
      xsusp_q <= xsusp_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xsusp_pin_n_q <= !USP_XSUSP_RST;
    end else if (ce_i) begin
      xsusp_pin_n_q <= xsusp_pin_n_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      suspx_prev_q <= USP_SUSPX_RST;
    end else if (ce_i) begin
      suspx_prev_q <= suspx_s;
    end
  end

  // One-cycle answer; unmapped address gives err
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
    end else if (ce_i) begin
      err_q <= err_d;
    end
  end

  // Data stays zero outside a read so stale values never leak
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h00000000;
    end else if (ce_i) begin
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;
  assign core_remote_wake_o = rwake_q;
  assign transceiver_reset_output_o = !xrst_q;
  assign transceiver_suspend_output_n_o = xsusp_pin_n_q;
  assign core_access_block_o = xsusp_q;
  // Combinational so the wake reaches the chip even with the clock stopped
  assign wake_interrupt_n_o = !(wake_en_q && core_suspend_n_i);

  a_rwake_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && suspx_s && !rwake_q |=> !rwake_q)
    else $error("remote wake set while not suspended");
  a_rwake_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && resume |=> !rwake_q)
    else $error("remote wake not cleared on resume");
  a_rwake_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_lo && wb_dat_i[USP_RWAKE_BIT] && !suspx_s && !resume |=> core_remote_wake_o)
    else $error("remote wake write lost");
  a_xrst_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_lo |=> transceiver_reset_output_o == !$past(wb_dat_i[USP_XRST_BIT]))
    else $error("transceiver reset pin wrong");
  a_xsusp_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    transceiver_suspend_output_n_o == !xsusp_q)
    else $error("transceiver suspend pin wrong");
  a_xsusp_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && resume |=> !xsusp_q && !core_access_block_o)
    else $error("transceiver suspend not cleared");
  a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_ok |=> wb_dat_o[USP_SUSPX_BIT] == $past(suspx_s))
    else $error("status bit read wrong");
  a_wake_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !wake_en_q |-> wake_interrupt_n_o)
    else $error("wake asserted while disabled");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // Bus handshake
  a_err_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_err_o |=> !wb_err_o)
    else $error("err held two cycles");

  a_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");

  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && hit |=> wb_ack_o)
    else $error("request not acknowledged");

  a_rdat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !rd_ok |=> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside a read");

  a_sel_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && hit && wb_we_i && !wb_sel_i[0] |=> $stable(xrst_q) && $stable(wake_en_q))
    else $error("write without lane 0 landed");

  a_err_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !hit |=> $stable(xrst_q) && $stable(wake_en_q))
    else $error("unmapped write landed");

  // Clock enable
  a_freeze_state: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(wake_en_q) && $stable(rwake_q) && $stable(xrst_q) && $stable(xsusp_q))
    else $error("state moved with clock enable low");

  a_freeze_bus: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(wb_ack_o) && $stable(wb_err_o) && $stable(wb_dat_o))
    else $error("bus answer moved with clock enable low");

  // Status path
  a_status_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##1 ce_i ##1 1'b1 |-> suspx_s == $past(core_suspend_n_i, 2))
    else $error("status not two flops behind input");

  a_spare_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_ok |=> wb_dat_o[31:8] == 24'h000000 && wb_dat_o[2:0] == 3'h0)
    else $error("unused read bits not zero");

  // Wake and remote wake
  a_wake_low: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_en_q && core_suspend_n_i |-> !wake_interrupt_n_o)
    else $error("wake not driven on resume");

  a_wake_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !core_suspend_n_i |-> wake_interrupt_n_o)
    else $error("wake driven while suspended");

  a_wake_en_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_ok |=> wb_dat_o[USP_WAKE_EN_BIT] == $past(wake_en_q))
    else $error("wake enable read wrong");

  a_rwake_write0: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_lo && !wd_rwake && !resume |=> rwake_q == $past(rwake_q))
    else $error("remote wake changed by a zero write");

  a_rwake_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_ok |=> wb_dat_o[USP_RWAKE_BIT] == $past(rwake_q))
    else $error("remote wake read wrong");

  // Transceiver pins
  a_xrst_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ce_i && wr_lo) |=> $stable(xrst_q))
    else $error("transceiver reset bit moved without a write");

  a_xrst_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_ok |=> wb_dat_o[USP_XRST_BIT] == $past(xrst_q))
    else $error("transceiver reset read wrong");

  a_xsusp_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_lo && wd_xsusp && !resume |=>
    !transceiver_suspend_output_n_o && core_access_block_o)
    else $error("transceiver suspend write lost");

  a_xsusp_write0: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_lo && !wd_xsusp |=>
    transceiver_suspend_output_n_o && !core_access_block_o)
    else $error("transceiver suspend not released");

  a_xsusp_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_ok |=> wb_dat_o[USP_XSUSP_BIT] == $past(xsusp_q))
    else $error("transceiver suspend read wrong");

  a_resume_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && resume |=> transceiver_suspend_output_n_o && !core_remote_wake_o)
    else $error("pins not released on resume");

  c_rwake: cover property (@(posedge clk_i) disable iff (rst_i) $rose(core_remote_wake_o));
  c_resume: cover property (@(posedge clk_i) disable iff (rst_i) resume && xsusp_q);
  c_wake: cover property (@(posedge clk_i) disable iff (rst_i) !wake_interrupt_n_o);
  c_err: cover property (@(posedge clk_i) disable iff (rst_i) wb_err_o);
  c_freeze: cover property (@(posedge clk_i) disable iff (rst_i) !ce_i && wb_cyc_i && wb_stb_i);
endmodule : usp_power_ctrl
`default_nettype wire

// ==== usp_sync.sv ====
/*
 Two-flop level synchroniser with a reset value.
 Assumes the input is a level from another timing domain.
*/
`timescale 1ns/10ps
`default_nettype none
module usp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_q;
  logic s2_q;
  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
    end else if (ce_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule : usp_sync
`default_nettype wire
